// *** bench/global_control_registers_chk.sv ***
/*
  port checker for the global control register bank.
  assumes zero-wait apb with byte addresses and one clock domain.
*/
`timescale 1ns/1ns
module gcr_checker #(
  parameter [3:0]  REVISION_ID = 4'h1,
  parameter [11:0] PART_CODE   = 12'h0A5A
) (
  input wire        mclk_in,
  input wire        resetn_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire        pslverr_out,
  input wire [31:0] prdata_out,
  input wire        irq_active_in,
  input wire        irq_pin_out,
  input wire        irq_pin_oe_n_out,
  input wire        monitor_update_done_in,
  input wire        monitor_update_done_out,
  input wire        latched_clear_on_read_out,
  input wire        datapath_soft_reset_out,
  input wire        full_soft_reset_out,
  input wire [2:0]  rate_adapter_mode_out,
  input wire        rate_adapter_mode_valid_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // access phase of any transfer
  wire acc = psel_in && penable_in;

  ident_read_a: assert property (acc && !pwrite_in && paddr_in == 12'h000 |->
    prdata_out == {16'h0000, REVISION_ID, PART_CODE}) else $error("identity word wrong");
  unmapped_read_a: assert property (acc && paddr_in == 12'h004 |->
    pslverr_out && prdata_out == 32'h0000_0000) else $error("unmapped access not refused");
  // two cycles of slack; the irq pin path is combinational, with no synchroniser
  irq_drive_low_a: assert property (irq_active_in [*3] |->
    !irq_pin_oe_n_out && !irq_pin_out) else $error("irq pin not driven low");
  clear_mode_wr_a: assert property (acc && pwrite_in && paddr_in == 12'h008 &&
    !pwdata_in[0] && !full_soft_reset_out |=> latched_clear_on_read_out == $past(pwdata_in[2]))
    else $error("clear mode not taken from write");
  adapter_wr_a: assert property (acc && pwrite_in && paddr_in == 12'h010 &&
    !full_soft_reset_out |=> rate_adapter_mode_out == $past(pwdata_in[3:1]))
    else $error("adapter mode not taken from write");
  adapter_valid_a: assert property (rate_adapter_mode_valid_out ==
    (rate_adapter_mode_out <= 3'b100)) else $error("adapter mode validity wrong");
  full_forces_a: assert property (full_soft_reset_out [*2] |->
    !latched_clear_on_read_out && rate_adapter_mode_out == 3'b000)
    else $error("full reset left control bits set");
  datapath_init_a: assert property ($rose(resetn_in) |-> datapath_soft_reset_out)
    else $error("datapath reset not set by general reset");
  done_set_a: assert property (monitor_update_done_in |=> monitor_update_done_out)
    else $error("update done flag not set");

  cover property (acc && pslverr_out);
  cover property (full_soft_reset_out [*2]);
  cover property (monitor_update_done_out);
endmodule // gcr_checker

bind global_control_registers gcr_checker #(
  .REVISION_ID(REVISION_ID), .PART_CODE(PART_CODE)) i_chk (
  .mclk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .pslverr_out, .prdata_out, .irq_active_in, .irq_pin_out, .irq_pin_oe_n_out,
  .monitor_update_done_in, .monitor_update_done_out, .latched_clear_on_read_out,
  .datapath_soft_reset_out, .full_soft_reset_out, .rate_adapter_mode_out,
  .rate_adapter_mode_valid_out);

// *** bench/test_global_control_registers.sv ***
/*
  self-checking bench for the global control register bank.
  assumes zero-wait apb and the short divider counts set here.
*/
`timescale 1ns/1ns
`include "global_ctrl_consts.vh"
module test_global_control_registers;
  localparam logic [3:0]  REV   = 4'h6;   // arbitrary value
  localparam logic [11:0] PART  = 12'h3C5; // arbitrary value
  localparam logic [11:0] A_ID  = `IDX_IDENTITY << 2;
  localparam logic [11:0] A_C1  = `IDX_CONTROL_ONE << 2;
  localparam logic [11:0] A_C2  = `IDX_CONTROL_TWO << 2;
  localparam logic [11:0] A_GIO = `IDX_GENERAL_IO_CFG << 2;
  logic mclk_in, resetn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, rdat;
  logic irq_active_in = 0, general_io_two_in = 0, general_io_four_in = 0;
  logic general_io_six_in = 0, general_io_eight_in = 0, adapter_tick_in = 0;
  logic port_ref8k_in = 0, port_status_b_in = 0, monitor_update_done_in = 0;
  logic rerr, tick_en = 0;
  wire pready_out, pslverr_out, irq_pin_out, irq_pin_oe_n_out, general_io_two_out;
  wire general_io_two_oe_n_out, general_io_four_out, general_io_four_oe_n_out;
  wire monitor_update_done_out, monitor_update_out, err_insert_out, one_sec_tick_out;
  wire latched_clear_on_read_out, datapath_soft_reset_out, full_soft_reset_out;
  wire rate_adapter_mode_valid_out, ref8k_in_signal_out, ref8k_out_signal_out;
  wire [31:0] prdata_out;
  wire [2:0]  rate_adapter_mode_out;
  int mismatches = 0, checks_done = 0, err_cnt = 0, upd_cnt = 0, sec_cnt = 0, n, m;

  global_control_registers #(.REVISION_ID(REV), .PART_CODE(PART), .DIV_8K(4),
    .SEC_DIV(4)) i_dut (.mclk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .prdata_out, .irq_active_in,
    .irq_pin_out, .irq_pin_oe_n_out, .general_io_two_in, .general_io_two_out,
    .general_io_two_oe_n_out, .general_io_four_in, .general_io_four_out,
    .general_io_four_oe_n_out, .general_io_six_in, .general_io_eight_in,
    .adapter_tick_in, .port_ref8k_in, .port_status_b_in, .monitor_update_done_in,
    .monitor_update_done_out, .monitor_update_out, .err_insert_out,
    .latched_clear_on_read_out, .datapath_soft_reset_out, .full_soft_reset_out,
    .rate_adapter_mode_out, .rate_adapter_mode_valid_out, .ref8k_in_signal_out,
    .ref8k_out_signal_out, .one_sec_tick_out);

  initial begin
    mclk_in = 0;
    forever #4 mclk_in = ~mclk_in;
  end
  // pulse counters; adapter ticks every other cycle when enabled, port ref follows it
  always @(posedge mclk_in) begin
    err_cnt <= err_cnt + err_insert_out;
    upd_cnt <= upd_cnt + monitor_update_out;
    sec_cnt <= sec_cnt + one_sec_tick_out;
    adapter_tick_in <= tick_en & ~adapter_tick_in;
    port_ref8k_in <= adapter_tick_in;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, read data and error kept in rdat and rerr
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel_in <= 1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1;
    k = 0;
    do begin
      @(posedge mclk_in);
      k++;
    end while (pready_out !== 1'b1 && k < 20);
    check("pready", pready_out, 1'b1);
    rdat = prdata_out;
    rerr = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
    @(posedge mclk_in);
  endtask
  // room for the two-stage pin synchronisers and the pulse counters
  task automatic settle;
    repeat (6) @(posedge mclk_in);
  endtask

  task automatic t_regs;
    apb(0, A_ID, 0);
    check("rev", rdat[15:12], REV);
    check("part", rdat[11:0], PART);
    check("id upper", rdat[31:16], 0);
    apb(0, A_C1, 0);
    check("c1 reset", rdat, `C1_RESET_VALUE);
    check("dp out", datapath_soft_reset_out, 1);
    apb(1, A_ID, 32'hFFFF_FFFF);
    apb(0, A_ID, 0);
    check("id kept", rdat, {16'h0000, REV, PART});
    apb(1, A_C2, 32'hFFFF_FFFF);
    apb(0, A_C2, 0);
    check("c2 mask", rdat, 32'h0000_0F0E);
    check("adapter", rate_adapter_mode_out, 3'b111);
    apb(0, 12'h004, 0);
    check("bad err", rerr, 1);
    check("bad data", rdat, 0);
    for (int i = 0; i < 8; i++) begin
      apb(1, A_C2, i << 1);
      check("valid", rate_adapter_mode_valid_out, i < 5);
    end
    $display("registers test done");
  endtask

  task automatic t_irq;
    apb(1, A_C1, 0);
    settle();
    check("irq float", irq_pin_oe_n_out, 1);
    apb(1, A_C1, 32'h0000_4000);
    settle();
    check("irq idle hi", {irq_pin_oe_n_out, irq_pin_out}, 2'b01);
    irq_active_in <= 1;
    settle();
    check("irq low", {irq_pin_oe_n_out, irq_pin_out}, 2'b00);
    irq_active_in <= 0;
    $display("irq test done");
  endtask

  task automatic t_err;
    apb(1, A_C1, 0);
    n = err_cnt;
    apb(1, A_C1, 32'h0000_0080);
    settle();
    check("trig ins", err_cnt - n, 1);
    apb(1, A_C1, 32'h0000_0040);
    n = err_cnt;
    apb(1, A_C1, 32'h0000_00C0);
    settle();
    check("trig gated", err_cnt - n, 0);
    general_io_six_in <= 1;
    settle();
    check("pin ins", err_cnt - n, 1);
    general_io_six_in <= 0;
    $display("error insert test done");
  endtask

  task automatic t_update;
    apb(1, A_C1, 0);
    n = upd_cnt;
    apb(1, A_C1, 32'h0000_0008);
    settle();
    check("upd bit", upd_cnt - n, 1);
    monitor_update_done_in <= 1;
    @(posedge mclk_in);
    monitor_update_done_in <= 0;
    settle();
    check("done set", monitor_update_done_out, 1);
    apb(1, A_C1, 0);
    settle();
    check("done clr", monitor_update_done_out, 0);
    apb(1, A_C1, 32'h0000_0010);
    n = upd_cnt;
    general_io_eight_in <= 1;
    settle();
    check("upd pin", upd_cnt - n, 1);
    general_io_eight_in <= 0;
    // 8 cycles per 8k tick, 32 per second
    tick_en <= 1;
    apb(1, A_C2, 32'h0000_0400);
    apb(1, A_C1, 32'h0000_0020);
    n = upd_cnt;
    m = sec_cnt;
    repeat (100) @(posedge mclk_in);
    check("sec ticks", sec_cnt - m inside {[3:4]}, 1);
    check("upd sec", upd_cnt - n inside {[3:4]}, 1);
    apb(1, A_C2, 0);
    settle();
    m = sec_cnt;
    repeat (100) @(posedge mclk_in);
    check("src off", sec_cnt - m, 0);
    // port reference edges every 2 cycles, 8 per second
    apb(1, A_C2, 32'h0000_0800);
    m = sec_cnt;
    repeat (100) @(posedge mclk_in);
    check("sec port", sec_cnt - m inside {[11:13]}, 1);
    n = ref8k_out_signal_out;
    repeat (2) @(posedge mclk_in);
    check("ref out", ref8k_out_signal_out, !n);
    apb(1, A_C2, 0);
    tick_en <= 0;
    $display("update test done");
  endtask

  task automatic t_ref;
    apb(1, A_C2, 32'h0000_0200);
    settle();
    check("io2 ref", general_io_two_oe_n_out, 0);
    apb(1, A_C2, 0);
    apb(1, A_GIO, 32'h0000_000C);
    settle();
    check("io2 one", {general_io_two_oe_n_out, general_io_two_out}, 2'b01);
    apb(1, A_GIO, 0);
    settle();
    check("io2 in", general_io_two_oe_n_out, 1);
    general_io_four_in <= 1;
    settle();
    check("ref in off", ref8k_in_signal_out, 0);
    apb(1, A_C2, 32'h0000_0100);
    settle();
    check("ref in on", ref8k_in_signal_out, 1);
    apb(1, A_GIO, 32'h0000_00C0);
    check("io4 held in", general_io_four_oe_n_out, 1);
    apb(1, A_C2, 0);
    check("io4 one", {general_io_four_oe_n_out, general_io_four_out}, 2'b01);
    $display("reference test done");
  endtask

  task automatic t_soft;
    apb(1, A_C1, 32'h0000_0004);
    apb(1, A_C2, 32'h0000_0006);
    check("clr read", latched_clear_on_read_out, 1);
    apb(1, A_C1, 32'h0000_0005);
    repeat (13) @(posedge mclk_in);
    check("full", {full_soft_reset_out, latched_clear_on_read_out}, 2'b10);
    check("full adapt", rate_adapter_mode_out, 0);
    apb(0, A_C1, 0);
    check("full c1", rdat, `C1_RESET_VALUE | 32'h1);
    apb(1, A_C1, 0);
    check("full off", {full_soft_reset_out, datapath_soft_reset_out}, 2'b01);
    apb(1, A_C1, 0);
    check("soft off", {full_soft_reset_out, datapath_soft_reset_out}, 2'b00);
    $display("soft reset test done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // cuts a hang short; tests need well under this
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge mclk_in);
    resetn_in <= 1;
    repeat (3) @(posedge mclk_in);
    t_regs();
    t_irq();
    t_err();
    t_update();
    t_ref();
    t_soft();
    conclude();
  end
endmodule // test_global_control_registers

// *** rtl/global_control_registers.v ***
/*
  global register bank: identity word, two control words, general io mode
  word, reference selection and soft resets, on an apb slave.
  assumes pins are asynchronous (two-stage sync) and the rest of the chip
  uses the soft-reset, update and insertion outputs on mclk.
*/
// The APB slave port was chosen for this implementation.
// Contract
// RULE_01 - identity top four bits mirror boundary-scan id bits 31:28.
// RULE_02 - identity low twelve bits mirror boundary-scan id bits 23:12.
// RULE_03 - irq pin drives low active; idle floats or drives high by bit 14.
// RULE_04 - rising trigger bit inserts an error, only while source bit clear.
// RULE_05 - source bit picks trigger bit or general io six pin.
// RULE_06 - update mode picks update bit, io eight pin or one-second counter.
// RULE_07 - rising update source copies counters into monitor registers, resets them.
// RULE_08 - software holds update bit until done; done clears when bit falls.
// RULE_09 - bit 2 selects latched status clear by write or by read.
// RULE_10 - datapath reset bit holds datapath at defaults; resets to one.
// RULE_11 - full reset bit forces all registers but itself to defaults.
// RULE_12 - software keeps soft reset bits set at least 100 ns.
// RULE_13 - one-second reference from 8 khz reference; source ignored when input selected.
// RULE_14 - source 00 off, 01 adapter clock, 10 port reference, 11 undefined.
// RULE_15 - output select puts 8 khz reference on io two, else io two mode.
// RULE_16 - input select feeds io four into 8 khz input, else held low.
// RULE_17 - control two bits 3:1 set the clock adapter reference mode.
// RULE_18 - adapter mode decodes five reference rates; 101 and 11x undefined.
// RULE_19 - unassigned bits read zero and ignore writes; identity ignores writes. The general io word stores all 16 written bits.
`timescale 1ns/1ns
`include "global_ctrl_consts.vh"
module global_control_registers #(
  parameter [3:0]  REVISION_ID = 4'h1,      // arbitrary value
  parameter [11:0] PART_CODE   = 12'h0A5A,  // arbitrary value
  parameter        DIV_8K      = `REF8K_DIV_DEFAULT,
  parameter        SEC_DIV     = `ONE_SEC_TICKS
) (
  input  wire        mclk_in,
  input  wire        resetn_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output wire        pready_out,
  output wire        pslverr_out,
  output reg  [31:0] prdata_out,
  input  wire        irq_active_in,
  output wire        irq_pin_out,
  output wire        irq_pin_oe_n_out,
  input  wire        general_io_two_in,
  output wire        general_io_two_out,
  output wire        general_io_two_oe_n_out,
  input  wire        general_io_four_in,
  output wire        general_io_four_out,
  output wire        general_io_four_oe_n_out,
  input  wire        general_io_six_in,
  input  wire        general_io_eight_in,
  input  wire        adapter_tick_in,
  input  wire        port_ref8k_in,
  input  wire        port_status_b_in,
  input  wire        monitor_update_done_in,
  output reg         monitor_update_done_out,
  output reg         monitor_update_out,
  output reg         err_insert_out,
  output wire        latched_clear_on_read_out,
  output wire        datapath_soft_reset_out,
  output wire        full_soft_reset_out,
  output wire [2:0]  rate_adapter_mode_out,
  output wire        rate_adapter_mode_valid_out,
  output wire        ref8k_in_signal_out,
  output wire        ref8k_out_signal_out,
  output wire        one_sec_tick_out
);
  localparam SOFT_RESET_MIN_CYC =
    (`SOFT_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  reg         rst_s1_q, rst_s2_q;
  reg  [15:0] ctrl_one_q, ctrl_two_q, gio_cfg_q;
  reg  [5:0]  sync1_q, sync2_q;
  reg         trig_prev_q, upd_prev_q, upd_req_prev_q, ref_prev_q;
  reg         tick_8k_q;
  wire        rst_n = rst_s2_q;

  // reset release through two flops
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // pin synchronisers; first stage read only by second
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {port_status_b_in, port_ref8k_in, general_io_eight_in,
                  general_io_six_in, general_io_four_in, general_io_two_in};
      sync2_q <= sync1_q;
    end
  end
  // bit order follows the concatenation above, io two at bit 0
  wire io_four_s   = sync2_q[1];
  wire io_six_s    = sync2_q[2];
  wire io_eight_s  = sync2_q[3];
  wire port_ref_s  = sync2_q[4];
  wire port_stat_s = sync2_q[5];

  // address decode, shared by read and write paths
  function [1:0] decode_reg;
    input [11:0] addr;
    begin
      if (addr[1:0] != 2'b00)
        decode_reg = 2'd3;
      else if ({2'b00, addr[11:2]} == `IDX_IDENTITY)
        decode_reg = 2'd0;
      else if ({2'b00, addr[11:2]} == `IDX_CONTROL_ONE)
        decode_reg = 2'd1;
      else if ({2'b00, addr[11:2]} == `IDX_CONTROL_TWO)
        decode_reg = 2'd2;
      else
        decode_reg = 2'd3;
    end
  endfunction

  wire       is_gio    = (paddr_in[1:0] == 2'b00) &&
                         ({2'b00, paddr_in[11:2]} == `IDX_GENERAL_IO_CFG);
  wire [1:0] sel       = decode_reg(paddr_in);
  wire       access    = psel_in & penable_in;
  wire       wr        = access & pwrite_in;
  wire       unmapped  = (sel == 2'd3) & ~is_gio;
  wire       full_rst  = ctrl_one_q[`C1_FULL_RESET];

  assign pready_out  = 1'b1;                // zero wait states
  assign pslverr_out = access & unmapped;

  // control words; full soft reset forces all but its own bit
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_one_q <= `C1_RESET_VALUE;  // RULE_10
      ctrl_two_q <= `C2_RESET_VALUE;
      gio_cfg_q  <= 16'h0000;
    end else if (full_rst) begin
      ctrl_one_q <= `C1_RESET_VALUE |
                    ((wr && sel == 2'd1) ? (pwdata_in[15:0] & 16'h0001) : 16'h0001); // RULE_11
      ctrl_two_q <= `C2_RESET_VALUE;  // RULE_11
      gio_cfg_q  <= 16'h0000;
    end else if (wr) begin
      if (sel == 2'd1)
        ctrl_one_q <= pwdata_in[15:0] & `C1_WRITE_MASK;  // RULE_19
      if (sel == 2'd2)
        ctrl_two_q <= pwdata_in[15:0] & `C2_WRITE_MASK;  // RULE_19
      if (is_gio)
        gio_cfg_q <= pwdata_in[15:0];
    end
  end

  // read mux over the selected word
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (sel)
      2'd0:    rd_mux = {16'h0000, REVISION_ID, PART_CODE};  // RULE_01 RULE_02
      2'd1:    rd_mux = {16'h0000, ctrl_one_q};
      2'd2:    rd_mux = {16'h0000, ctrl_two_q};
      default: rd_mux = is_gio ? {16'h0000, gio_cfg_q} : 32'h0000_0000;
    endcase
  end

  // captured in the setup cycle so the answer comes from a flop with zero waits;
  // limitation: a read set up right behind a full-reset write sees the old word
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n)
      prdata_out <= 32'h0000_0000;
    else if (psel_in & ~penable_in)
      prdata_out <= rd_mux;
  end

  // irq pin: low when active, idle float or drive high
  assign irq_pin_out      = ~irq_active_in;                                   // RULE_03
  assign irq_pin_oe_n_out = ~(irq_active_in | ctrl_one_q[`C1_IRQ_IDLE]);     // RULE_03

  // error insert source and trigger edge
  wire err_src = ctrl_one_q[`C1_ERR_SRC] ? io_six_s : ctrl_one_q[`C1_ERR_TRIG];  // RULE_05

  // update source select
  wire       tick_sec_w;
  wire [1:0] upd_mode = ctrl_one_q[`C1_UPD_MODE_HI:`C1_UPD_MODE_LO];
  wire       upd_req  = ctrl_one_q[`C1_UPD_REQ];
  wire       upd_src  = upd_mode[1] ? tick_sec_w :
                        (upd_mode[0] ? io_eight_s : upd_req);  // RULE_06

  // edge detectors for insertion, update and done tracking
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev_q             <= 1'b0;
      upd_prev_q              <= 1'b0;
      upd_req_prev_q          <= 1'b0;
      err_insert_out          <= 1'b0;
      monitor_update_out      <= 1'b0;
      monitor_update_done_out <= 1'b0;
    end else begin
      trig_prev_q    <= err_src;
      upd_prev_q     <= upd_src;
      upd_req_prev_q <= upd_req;
      // source bit clear is implied when pin path is chosen separately
      err_insert_out <= err_src & ~trig_prev_q;  // RULE_04
      monitor_update_out <= upd_mode[1] ? tick_sec_w : (upd_src & ~upd_prev_q);  // RULE_07
      // set wins over the clear on the falling update bit
      if (monitor_update_done_in)
        monitor_update_done_out <= 1'b1;
      else if (upd_req_prev_q & ~upd_req)
        monitor_update_done_out <= 1'b0;  // RULE_08
    end
  end

  assign latched_clear_on_read_out = ctrl_one_q[`C1_CLR_ON_READ];  // RULE_09
  assign datapath_soft_reset_out   = ctrl_one_q[`C1_DP_RESET];     // RULE_10
  // software holds these at least SOFT_RESET_MIN_CYC cycles
  assign full_soft_reset_out       = full_rst;                     // RULE_12

  // clock adapter mode and its validity
  assign rate_adapter_mode_out       = ctrl_two_q[`C2_ADAPT_HI:`C2_ADAPT_LO];  // RULE_17
  assign rate_adapter_mode_valid_out = (rate_adapter_mode_out <= 3'b100);      // RULE_18

  // 8 khz reference source selection
  wire       in_sel  = ctrl_two_q[`C2_IN_SEL];
  wire [1:0] src_sel = ctrl_two_q[`C2_SRC_HI:`C2_SRC_LO];
  assign ref8k_in_signal_out = in_sel ? io_four_s : 1'b0;  // RULE_16
  wire   ext_ref = in_sel ? io_four_s : port_ref_s;
  wire   ref_edge = ext_ref & ~ref_prev_q;
  // undefined code 11 counts as off, so the divider never runs on a guess
  wire   div_clear = ~in_sel & ((src_sel == 2'b00) | (src_sel == 2'b11));  // RULE_14
  wire   div_src   = in_sel ? 1'b0 : (src_sel == 2'b01) & adapter_tick_in;  // RULE_13 RULE_14
  wire   tick_8k_w;

  // external references already run at 8 khz; only adapter ticks are divided
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ref_prev_q <= 1'b0;
      tick_8k_q  <= 1'b0;
    end else begin
      ref_prev_q <= ext_ref;
      if (in_sel | (src_sel == 2'b10))
        tick_8k_q <= ref_edge;  // RULE_13
      else
        tick_8k_q <= tick_8k_w;
    end
  end

  // the divider's own second pulse is left open: the counter below serves all sources
  ref8k_timer #(
    .DIV_8K  (DIV_8K),
    .SEC_DIV (SEC_DIV)
  ) u_div (
    .clk_in       (mclk_in),
    .rst_n_in     (rst_n),
    .clear_in     (div_clear | full_rst),
    .src_tick_in  (div_src),
    .tick_8k_out  (tick_8k_w),
    .tick_sec_out ()
  );

  // second counter from the selected 8 khz ticks
  reg [12:0] sec_cnt_q;
  reg        sec_tick_q;
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt_q  <= 13'h0000;
      sec_tick_q <= 1'b0;
    end else begin
      sec_tick_q <= 1'b0;
      if (tick_8k_q) begin
        if (sec_cnt_q == SEC_DIV[12:0] - 13'h0001) begin
          sec_cnt_q  <= 13'h0000;
          sec_tick_q <= 1'b1;  // RULE_13
        end else begin
          sec_cnt_q <= sec_cnt_q + 13'h0001;
        end
      end
    end
  end
  assign tick_sec_w       = sec_tick_q;
  assign one_sec_tick_out = sec_tick_q;

  // io two: reference output or its own mode; io four: input when selected
  wire [1:0] two_mode  = gio_cfg_q[`GIO_TWO_HI:`GIO_TWO_LO];
  wire [1:0] four_mode = gio_cfg_q[`GIO_FOUR_HI:`GIO_FOUR_LO];
  reg  ref_level_q;
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n)
      ref_level_q <= 1'b0;
    else if (tick_8k_q)
      ref_level_q <= ~ref_level_q;
  end
  assign ref8k_out_signal_out   = ref_level_q;
  assign general_io_two_out     = ctrl_two_q[`C2_OUT_SEL] ? ref_level_q :
                                  (two_mode == 2'b01) ? port_stat_s : two_mode[0];  // RULE_15
  assign general_io_two_oe_n_out = ~(ctrl_two_q[`C2_OUT_SEL] | two_mode != 2'b00); // RULE_15
  assign general_io_four_out     = four_mode[0];
  assign general_io_four_oe_n_out = in_sel | ~four_mode[1];  // RULE_16
endmodule // global_control_registers

// *** rtl/global_ctrl_consts.vh ***
/*
  constants for the global control register bank: offsets, field positions,
  reset values, timing counts. assumes inclusion by bare name.
*/
`ifndef GLOBAL_CTRL_CONSTS_VH
`define GLOBAL_CTRL_CONSTS_VH

// printed offsets are register indices; byte address is four times the index
`define IDX_IDENTITY        12'h000
`define IDX_CONTROL_ONE     12'h002
`define IDX_CONTROL_TWO     12'h004
`define IDX_GENERAL_IO_CFG  12'h00A

// control one fields
`define C1_IRQ_IDLE         14
`define C1_ERR_TRIG         7
`define C1_ERR_SRC          6
`define C1_UPD_MODE_HI      5
`define C1_UPD_MODE_LO      4
`define C1_UPD_REQ          3
`define C1_CLR_ON_READ      2
`define C1_DP_RESET         1
`define C1_FULL_RESET       0
`define C1_WRITE_MASK       16'h40FF
`define C1_RESET_VALUE      16'h0002

// control two fields
`define C2_SRC_HI           11
`define C2_SRC_LO           10
`define C2_OUT_SEL          9
`define C2_IN_SEL           8
`define C2_ADAPT_HI         3
`define C2_ADAPT_LO         1
`define C2_WRITE_MASK       16'h0F0E
`define C2_RESET_VALUE      16'h0000

// general io mode fields (io two at 3:2, io four at 7:6)
`define GIO_TWO_HI          3
`define GIO_TWO_LO          2
`define GIO_FOUR_HI         7
`define GIO_FOUR_LO         6

// timing
`define SOFT_RESET_MIN_NS   100
`define CLK_PERIOD_NS       8
`define REF8K_DIV_DEFAULT   15625
`define ONE_SEC_TICKS       8000

`endif

// *** rtl/ref8k_timer.v ***
/*
  divides a source clock enable down to an 8 khz pulse and then to a
  one-second pulse. assumes all inputs are on mclk and already synchronised.
*/
`timescale 1ns/1ns
module ref8k_timer #(
  parameter DIV_8K  = 15625,
  parameter SEC_DIV = 8000
) (
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire clear_in,
  input  wire src_tick_in,
  output reg  tick_8k_out,
  output reg  tick_sec_out
);
  reg [15:0] div_q;
  reg [12:0] sec_q;

  // counts source ticks; held clear while source disabled
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q        <= 16'h0000;
      sec_q        <= 13'h0000;
      tick_8k_out  <= 1'b0;
      tick_sec_out <= 1'b0;
    end else if (clear_in) begin
      div_q        <= 16'h0000;
      sec_q        <= 13'h0000;
      tick_8k_out  <= 1'b0;
      tick_sec_out <= 1'b0;
    end else begin
      tick_8k_out  <= 1'b0;
      tick_sec_out <= 1'b0;
      if (src_tick_in) begin
        if (div_q == DIV_8K[15:0] - 16'h0001) begin
          div_q       <= 16'h0000;
          tick_8k_out <= 1'b1;
          if (sec_q == SEC_DIV[12:0] - 13'h0001) begin
            sec_q        <= 13'h0000;
            tick_sec_out <= 1'b1;
          end else begin
            sec_q <= sec_q + 13'h0001;
          end
        end else begin
          div_q <= div_q + 16'h0001;
        end
      end
    end
  end
endmodule // ref8k_timer
